/* logic/temp_limit_pkg.sv */
// Command codes, field layouts, reset values and encodings for the temperature limit block.
// Assumes one core clock and a separate link clock for the command transport.
package temp_limit_pkg;

  localparam int CODE_W = 8;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;

  // Command codes reached through the link
  localparam logic [7:0] CODE_OPERATION     = 8'h01;
  localparam logic [7:0] CODE_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CODE_OT_WARN_LIM   = 8'h51;
  localparam logic [7:0] CODE_UT_WARN_LIM   = 8'h52;
  localparam logic [7:0] CODE_UT_FAULT_LIM  = 8'h53;
  localparam logic [7:0] CODE_UT_FAULT_RESP = 8'h54;
  localparam logic [7:0] CODE_STATUS_TEMP   = 8'h7d;

  // Fault action byte layout
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_DELAY   = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_LATCH   = 2'h3;

  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Operation byte: bit 7 commands the output on
  localparam int OP_ON_BIT = 7;

  // Temperature status byte bits
  localparam int STAT_OT_WARN_BIT  = 6;
  localparam int STAT_UT_WARN_BIT  = 5;
  localparam int STAT_UT_FAULT_BIT = 4;

  // Reset values
  localparam logic [15:0] OT_WARN_RESET  = 16'h7fff;
  localparam logic [15:0] UT_WARN_RESET  = 16'h8000;
  localparam logic [15:0] UT_FAULT_RESET = 16'h8000;
  localparam logic [7:0]  ACTION_RESET   = 8'h00;
  localparam logic [7:0]  OPERATION_RESET = 8'h80;

  localparam int DELAY_CNT_W = 8;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_DELAY,
    ST_WAIT,
    ST_LATCH
  } fault_state_e;

endpackage

/* logic/link_cmd_sync.sv */
// Carries one command at a time from the link clock domain to the core clock domain and the
// answer back, by a toggle handshake. Assumes fields are read by the core only after the toggle.
`timescale 1ns/1ps
module link_cmd_sync
  import temp_limit_pkg::*;
(
  input  wire logic              link_clk_i,
  input  wire logic              link_rst_n_i,
  input  wire logic              link_req_i,
  input  wire logic              link_write_i,
  input  wire logic [CODE_W-1:0] link_code_i,
  input  wire logic [WORD_W-1:0] link_wdata_i,
  output logic                   link_busy_o,
  output logic                   link_done_o,
  output logic [WORD_W-1:0]      link_rdata_o,
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  output logic                   cmd_valid_o,
  output logic                   cmd_write_o,
  output logic [CODE_W-1:0]      cmd_code_o,
  output logic [WORD_W-1:0]      cmd_wdata_o,
  input  wire logic [WORD_W-1:0] cmd_rdata_i
);

  logic              req_tgl_reg;
  logic              busy_reg;
  logic              write_reg;
  logic [CODE_W-1:0] code_reg;
  logic [WORD_W-1:0] wdata_reg;
  logic [2:0]        ack_sync_reg;
  logic              done_reg;
  logic [WORD_W-1:0] link_rdata_reg;
  logic [2:0]        req_sync_reg;
  logic              ack_tgl_reg;
  logic [WORD_W-1:0] core_rdata_reg;
  logic              ack_seen;
  logic              req_seen;

  assign ack_seen = ack_sync_reg[2] ^ ack_sync_reg[1];
  assign req_seen = req_sync_reg[2] ^ req_sync_reg[1];

  // Link side: fields stay frozen while busy, so the core can sample them safely
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i) begin
      req_tgl_reg <= 1'b0;
      busy_reg    <= 1'b0;
      write_reg   <= 1'b0;
      code_reg    <= '0;
      wdata_reg   <= '0;
    end else if (link_req_i && !busy_reg) begin
      req_tgl_reg <= ~req_tgl_reg;
      busy_reg    <= 1'b1;
      write_reg   <= link_write_i;
      code_reg    <= link_code_i;
      wdata_reg   <= link_wdata_i;
    end else if (ack_seen) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i) begin
      ack_sync_reg   <= '0;
      done_reg       <= 1'b0;
      link_rdata_reg <= '0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
      done_reg     <= ack_seen;
      if (ack_seen) begin
        link_rdata_reg <= core_rdata_reg;
      end
    end
  end

  // Core side: a stalled clock enable holds the request until it can be served
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      req_sync_reg   <= '0;
      ack_tgl_reg    <= 1'b0;
      core_rdata_reg <= '0;
    end else if (clk_en_i) begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      if (req_seen) begin
        ack_tgl_reg    <= ~ack_tgl_reg;
        core_rdata_reg <= cmd_rdata_i;
      end
    end
  end

  assign cmd_valid_o  = req_seen && clk_en_i;
  assign cmd_write_o  = write_reg;
  assign cmd_code_o   = code_reg;
  assign cmd_wdata_o  = wdata_reg;
  assign link_busy_o  = busy_reg;
  assign link_done_o  = done_reg;
  assign link_rdata_o = link_rdata_reg;

endmodule

/* logic/unit_delay_timer.sv */
// Counts 2**n delay-unit ticks after a start pulse and pulses done in the cycle after the last tick.
// Assumes the unit tick is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module unit_delay_timer
  import temp_limit_pkg::*;
#(
  parameter int CNT_W = DELAY_CNT_W
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       start_i,
  input  wire logic       stop_i,
  input  wire logic       unit_tick_i,
  input  wire logic [2:0] exp_i,
  output logic            done_o
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] target_reg;
  logic             run_reg;
  logic             done_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      count_reg  <= '0;
      target_reg <= '0;
      run_reg    <= 1'b0;
      done_reg   <= 1'b0;
    end else if (clk_en_i) begin
      done_reg <= 1'b0;
      if (stop_i) begin
        run_reg <= 1'b0;
      end else if (start_i) begin
        run_reg    <= 1'b1;
        count_reg  <= '0;
        target_reg <= CNT_W'(1) << exp_i;  // [RQ13]
      end else if (run_reg && unit_tick_i) begin
        if (count_reg + CNT_W'(1) == target_reg) begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
        end
        count_reg <= count_reg + CNT_W'(1);
      end
    end
  end

  assign done_o = done_reg;

endmodule

/* logic/temp_limit_fault_response.sv */
// Temperature limit command registers and the under-temperature fault response sequencer.
// Assumes commands arrive from link transport logic on link_clk_i, the temperature reading and
// delay-unit tick come from core-clock logic, and the remote on/off pin is asynchronous.
`timescale 1ns/1ps

// How it works
// RQ1: Over-temperature warning threshold, 16 bits, read and written at code 0x51.
// RQ2: Under-temperature warning threshold, 16 bits, read and written at code 0x52.
// RQ3: Under-temperature fault threshold, 16 bits, read and written at code 0x53.
// RQ4: Response 00 keeps the output running while the fault stays.
// RQ5: Response 01 runs for the delay, then acts per retry field if fault persists.
// RQ6: Response 10 disables at once, then restarts as the retry field selects.
// RQ7: Response 11 disables and holds off until the fault is cleared.
// RQ8: Clear by status bit write, clear-faults command or reset.
// RQ9: Clear also when output is commanded off then back on by pin or operation.
// RQ10: Retry field 000 means no restart; output stays off until cleared.
// RQ11: Retry 001 to 101 gives that many attempts, then off until cleared.
// RQ12: Attempt starts are spaced by the time the delay field sets, counted in delay units.
// RQ13: Delay field n means 2 to the n delay units, 1 to 128.
// RQ14: Retry 110 gives six attempts; 111 retries until commanded off.
// RQ15: Fault below fault threshold; warnings below UT warn or above OT warn.
module temp_limit_fault_response
  import temp_limit_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  input  wire logic              link_clk_i,
  input  wire logic              link_rst_n_i,
  input  wire logic              link_req_i,
  input  wire logic              link_write_i,
  input  wire logic [CODE_W-1:0] link_code_i,
  input  wire logic [WORD_W-1:0] link_wdata_i,
  output logic                   link_busy_o,
  output logic                   link_done_o,
  output logic [WORD_W-1:0]      link_rdata_o,
  input  wire logic [WORD_W-1:0] temp_i,
  input  wire logic              unit_tick_i,
  input  wire logic              ctrl_pin_i,
  output logic                   pwr_en_o,
  output logic                   ut_fault_o,
  output logic                   ut_warn_o,
  output logic                   ot_warn_o,
  output logic [2:0]             attempts_o
);

  logic              cmd_valid;
  logic              cmd_write;
  logic [CODE_W-1:0] cmd_code;
  logic [WORD_W-1:0] cmd_wdata;
  logic [WORD_W-1:0] cmd_rdata;

  logic [WORD_W-1:0] ot_warn_lim_reg;
  logic [WORD_W-1:0] ut_warn_lim_reg;
  logic [WORD_W-1:0] ut_fault_lim_reg;
  logic [BYTE_W-1:0] action_reg;
  logic [BYTE_W-1:0] operation_reg;
  logic              ut_fault_flag_reg;
  logic              ut_warn_flag_reg;
  logic              ot_warn_flag_reg;
  logic [1:0]        ctrl_sync_reg;
  logic              out_on_q_reg;
  fault_state_e      state_reg;
  fault_state_e      state_next;
  logic [2:0]        attempts_reg;
  logic [2:0]        attempts_next;
  logic              pwr_en_reg;

  logic       wr_ot_warn;
  logic       wr_ut_warn;
  logic       wr_ut_fault;
  logic       wr_action;
  logic       wr_operation;
  logic       wr_status;
  logic       cmd_clear_all;
  logic       out_on;
  logic       on_rise;
  logic       clear_ut_fault;
  logic       clear_ut_warn;
  logic       clear_ot_warn;
  logic       fault_now;
  logic       ut_warn_now;
  logic       ot_warn_now;

  logic [1:0] resp;
  logic [2:0] retry_lim;
  logic [2:0] delay_exp;
  logic       timer_start;
  logic       timer_stop;
  logic       timer_done;

  // A write command aimed at one code
  function automatic logic is_write(input logic valid, input logic wr, input logic [CODE_W-1:0] code,
                                    input logic [CODE_W-1:0] target);
    is_write = valid && wr && (code == target);
  endfunction

  // Whether the retry budget is used up after this many attempts
  function automatic logic retries_spent(input logic [2:0] limit, input logic [2:0] done_cnt);
    retries_spent = (limit != RETRY_FOREVER) && (done_cnt >= limit);  // [RQ11] [RQ14]
  endfunction

  link_cmd_sync u_link (
    .link_clk_i   (link_clk_i),
    .link_rst_n_i (link_rst_n_i),
    .link_req_i   (link_req_i),
    .link_write_i (link_write_i),
    .link_code_i  (link_code_i),
    .link_wdata_i (link_wdata_i),
    .link_busy_o  (link_busy_o),
    .link_done_o  (link_done_o),
    .link_rdata_o (link_rdata_o),
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .clk_en_i     (clk_en_i),
    .cmd_valid_o  (cmd_valid),
    .cmd_write_o  (cmd_write),
    .cmd_code_o   (cmd_code),
    .cmd_wdata_o  (cmd_wdata),
    .cmd_rdata_i  (cmd_rdata)
  );

  assign wr_ot_warn    = is_write(cmd_valid, cmd_write, cmd_code, CODE_OT_WARN_LIM);
  assign wr_ut_warn    = is_write(cmd_valid, cmd_write, cmd_code, CODE_UT_WARN_LIM);
  assign wr_ut_fault   = is_write(cmd_valid, cmd_write, cmd_code, CODE_UT_FAULT_LIM);
  assign wr_action     = is_write(cmd_valid, cmd_write, cmd_code, CODE_UT_FAULT_RESP);
  assign wr_operation  = is_write(cmd_valid, cmd_write, cmd_code, CODE_OPERATION);
  assign wr_status     = is_write(cmd_valid, cmd_write, cmd_code, CODE_STATUS_TEMP);
  // Clear-faults carries no data, so either direction of the command counts
  assign cmd_clear_all = cmd_valid && (cmd_code == CODE_CLEAR_FAULTS);  // [RQ8]

  // Read answer; unknown codes read as zero
  always_comb begin
    cmd_rdata = '0;
    if (cmd_code == CODE_OT_WARN_LIM) begin
      cmd_rdata = ot_warn_lim_reg;  // [RQ1]
    end else if (cmd_code == CODE_UT_WARN_LIM) begin
      cmd_rdata = ut_warn_lim_reg;  // [RQ2]
    end else if (cmd_code == CODE_UT_FAULT_LIM) begin
      cmd_rdata = ut_fault_lim_reg;  // [RQ3]
    end else if (cmd_code == CODE_UT_FAULT_RESP) begin
      cmd_rdata = {{(WORD_W-BYTE_W){1'b0}}, action_reg};
    end else if (cmd_code == CODE_OPERATION) begin
      cmd_rdata = {{(WORD_W-BYTE_W){1'b0}}, operation_reg};
    end else if (cmd_code == CODE_STATUS_TEMP) begin
      cmd_rdata[STAT_OT_WARN_BIT]  = ot_warn_flag_reg;
      cmd_rdata[STAT_UT_WARN_BIT]  = ut_warn_flag_reg;
      cmd_rdata[STAT_UT_FAULT_BIT] = ut_fault_flag_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ot_warn_lim_reg  <= OT_WARN_RESET;
      ut_warn_lim_reg  <= UT_WARN_RESET;
      ut_fault_lim_reg <= UT_FAULT_RESET;
      action_reg       <= ACTION_RESET;
      operation_reg    <= OPERATION_RESET;
    end else if (clk_en_i) begin
      if (wr_ot_warn) begin
        ot_warn_lim_reg <= cmd_wdata;  // [RQ1]
      end
      if (wr_ut_warn) begin
        ut_warn_lim_reg <= cmd_wdata;  // [RQ2]
      end
      if (wr_ut_fault) begin
        ut_fault_lim_reg <= cmd_wdata;  // [RQ3]
      end
      if (wr_action) begin
        action_reg <= cmd_wdata[BYTE_W-1:0];
      end
      if (wr_operation) begin
        operation_reg <= cmd_wdata[BYTE_W-1:0];
      end
    end
  end

  // Remote on/off pin is asynchronous
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_sync_reg <= '0;
      out_on_q_reg  <= 1'b0;
    end else if (clk_en_i) begin
      ctrl_sync_reg <= {ctrl_sync_reg[0], ctrl_pin_i};
      out_on_q_reg  <= out_on;
    end
  end

  assign out_on  = operation_reg[OP_ON_BIT] && ctrl_sync_reg[1];
  // Off-to-on edge clears latches
  assign on_rise = out_on && !out_on_q_reg;  // [RQ9]

  // Linear-format words are compared as signed integers of the same scale
  assign fault_now   = $signed(temp_i) < $signed(ut_fault_lim_reg);  // [RQ15]
  assign ut_warn_now = $signed(temp_i) < $signed(ut_warn_lim_reg);   // [RQ15]
  assign ot_warn_now = $signed(temp_i) > $signed(ot_warn_lim_reg);   // [RQ15]

  assign clear_ut_fault = cmd_clear_all || on_rise || (wr_status && cmd_wdata[STAT_UT_FAULT_BIT]);  // [RQ8] [RQ9]
  assign clear_ut_warn  = cmd_clear_all || on_rise || (wr_status && cmd_wdata[STAT_UT_WARN_BIT]);
  assign clear_ot_warn  = cmd_clear_all || on_rise || (wr_status && cmd_wdata[STAT_OT_WARN_BIT]);

  // Sticky flags: a condition present in the clearing cycle keeps its flag set
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ut_fault_flag_reg <= 1'b0;
      ut_warn_flag_reg  <= 1'b0;
      ot_warn_flag_reg  <= 1'b0;
    end else if (clk_en_i) begin
      ut_fault_flag_reg <= fault_now || (ut_fault_flag_reg && !clear_ut_fault);  // [RQ8]
      ut_warn_flag_reg  <= ut_warn_now || (ut_warn_flag_reg && !clear_ut_warn);
      ot_warn_flag_reg  <= ot_warn_now || (ot_warn_flag_reg && !clear_ot_warn);
    end
  end

  assign resp      = action_reg[RESP_MSB:RESP_LSB];
  assign retry_lim = action_reg[RETRY_MSB:RETRY_LSB];
  assign delay_exp = action_reg[DELAY_MSB:DELAY_LSB];

  unit_delay_timer #(
    .CNT_W (DELAY_CNT_W)
  ) u_timer (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .start_i     (timer_start),
    .stop_i      (timer_stop),
    .unit_tick_i (unit_tick_i),
    .exp_i       (delay_exp),
    .done_o      (timer_done)
  );

  // Response sequencer; a failed attempt leaves the output off and, unless it uses up the retry limit, waits out one more interval
  always_comb begin
    state_next    = state_reg;
    attempts_next = attempts_reg;
    timer_start   = 1'b0;
    timer_stop    = 1'b0;
    if (!out_on) begin
      // Commanded off ends any delay, retry series or latch
      state_next    = ST_RUN;
      attempts_next = '0;
      timer_stop    = 1'b1;  // [RQ14]
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (fault_now) begin
            case (resp)
              RESP_IGNORE: begin
                state_next = ST_RUN;  // [RQ4]
              end
              RESP_DELAY: begin
                state_next  = ST_DELAY;  // [RQ5]
                timer_start = 1'b1;
              end
              RESP_DISABLE: begin
                attempts_next = '0;
                if (retry_lim == RETRY_NONE) begin
                  state_next = ST_LATCH;  // [RQ6] [RQ10]
                end else begin
                  state_next  = ST_WAIT;  // [RQ6] [RQ12]
                  timer_start = 1'b1;
                end
              end
              default: begin
                state_next = ST_LATCH;  // [RQ7]
              end
            endcase
          end
        end

        ST_DELAY: begin
          if (timer_done) begin
            attempts_next = '0;
            if (!fault_now) begin
              state_next = ST_RUN;
            end else if (retry_lim == RETRY_NONE) begin
              state_next = ST_LATCH;  // [RQ5] [RQ10]
            end else begin
              state_next  = ST_WAIT;  // [RQ5]
              timer_start = 1'b1;
            end
          end
        end

        ST_WAIT: begin
          if (timer_done) begin
            attempts_next = attempts_reg + 3'h1;
            if (!fault_now) begin
              state_next    = ST_RUN;
              attempts_next = '0;
            end else if (retries_spent(retry_lim, attempts_reg + 3'h1)) begin
              state_next = ST_LATCH;  // [RQ11] [RQ14]
            end else begin
              timer_start = 1'b1;  // [RQ12]
              if (retry_lim == RETRY_FOREVER) begin
                attempts_next = attempts_reg;  // [RQ14]
              end
            end
          end
        end

        ST_LATCH: begin
          // A fault still present re-arms the response at once
          if (clear_ut_fault) begin
            state_next    = ST_RUN;  // [RQ7] [RQ8] [RQ9]
            attempts_next = '0;
          end
        end

        default: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_RUN;
      attempts_reg <= '0;
    end else if (clk_en_i) begin
      state_reg    <= state_next;
      attempts_reg <= attempts_next;
    end
  end

  // Output runs in normal operation and during the keep-running delay
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pwr_en_reg <= 1'b0;
    end else if (clk_en_i) begin
      pwr_en_reg <= out_on && ((state_next == ST_RUN) || (state_next == ST_DELAY));  // [RQ4] [RQ6] [RQ7]
    end
  end

  assign pwr_en_o   = pwr_en_reg;
  assign ut_fault_o = ut_fault_flag_reg;
  assign ut_warn_o  = ut_warn_flag_reg;
  assign ot_warn_o  = ot_warn_flag_reg;
  assign attempts_o = attempts_reg;

endmodule

/* dv/temp_limit_fault_response_chk.sv */
// Port assertions for the temperature limit block, in both clock domains.
// Assumes clk_en_i stays high; bound to the top module at the foot of this file.
`timescale 1ns/1ps
module temp_limit_fault_response_chk (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        link_clk_i,
  input  wire logic        link_rst_n_i,
  input  wire logic        link_req_i,
  input  wire logic        link_busy_o,
  input  wire logic        link_done_o,
  input  wire logic [15:0] link_rdata_o,
  input  wire logic        ctrl_pin_i,
  input  wire logic        pwr_en_o,
  input  wire logic [2:0]  attempts_o
);
  property p_pin_off;
    @(posedge clock_i) disable iff (!rst_n_i) !ctrl_pin_i [*3] |=> !pwr_en_o;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("output on with pin held off");
  property p_pin_on;
    @(posedge clock_i) disable iff (!rst_n_i) $rose(pwr_en_o) |-> $past(ctrl_pin_i, 3);
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("output rose without pin on");
  property p_attempt_off;
    @(posedge clock_i) disable iff (!rst_n_i) attempts_o != 3'h0 && $changed(attempts_o) |-> !pwr_en_o;
  endproperty
  a_attempt_off: assert property (p_attempt_off) else $error("failed attempt with output on");
  property p_attempt_step;
    @(posedge clock_i) disable iff (!rst_n_i)
      $changed(attempts_o) && attempts_o != 3'h0 |-> attempts_o == $past(attempts_o) + 3'h1;
  endproperty
  a_attempt_step: assert property (p_attempt_step) else $error("attempt count skipped");
  property p_attempt_max;
    @(posedge clock_i) disable iff (!rst_n_i) attempts_o != 3'h7;
  endproperty
  a_attempt_max: assert property (p_attempt_max) else $error("attempt count above six");
  property p_req_busy;
    @(posedge link_clk_i) disable iff (!link_rst_n_i) link_req_i && !link_busy_o |=> link_busy_o;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("taken command not busy");
  property p_answer;
    @(posedge link_clk_i) disable iff (!link_rst_n_i) link_req_i && !link_busy_o |-> ##[2:16] link_done_o;
  endproperty
  a_answer: assert property (p_answer) else $error("command never answered");
  property p_done_once;
    @(posedge link_clk_i) disable iff (!link_rst_n_i) link_done_o |=> !link_done_o && !link_busy_o;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done not a single pulse");
  property p_busy_end;
    @(posedge link_clk_i) disable iff (!link_rst_n_i) $fell(link_busy_o) |-> link_done_o;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
  property p_rdata_hold;
    @(posedge link_clk_i) disable iff (!link_rst_n_i) !link_done_o |-> $stable(link_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between answers");
  c_done: cover property (@(posedge link_clk_i) link_done_o);
  c_six: cover property (@(posedge clock_i) attempts_o == 3'h6);
  c_off: cover property (@(posedge clock_i) $fell(pwr_en_o));
endmodule

bind temp_limit_fault_response temp_limit_fault_response_chk i_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .link_rst_n_i(link_rst_n_i),
  .link_req_i(link_req_i), .link_busy_o(link_busy_o), .link_done_o(link_done_o),
  .link_rdata_o(link_rdata_o), .ctrl_pin_i(ctrl_pin_i), .pwr_en_o(pwr_en_o), .attempts_o(attempts_o));

/* dv/link_host_model.sv */
// Command host at the far side of the link, one command outstanding at a time.
// Assumes a single bench process calls xfer; drives only on falling link edges.
`timescale 1ns/1ps
module link_host_model (
  input  wire logic        link_clk_i,
  input  wire logic        busy_i,
  input  wire logic        done_i,
  input  wire logic [15:0] rdata_i,
  output logic             req_o = 1'b0,
  output logic             write_o = 1'b0,
  output logic [7:0]       code_o = 8'h00,
  output logic [15:0]      wdata_o = 16'h0000
);
  // Next command waits for the previous answer
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] q);
    @(negedge link_clk_i);
    while (busy_i) @(negedge link_clk_i);
    req_o = 1'b1;
    write_o = wr;
    code_o = code;
    wdata_o = data;
    @(posedge link_clk_i);
    @(negedge link_clk_i);
    // Released lines show no stale value
    req_o = 1'b0;
    write_o = ~wr;
    code_o = ~code;
    wdata_o = ~data;
    while (!done_i) @(negedge link_clk_i);
    q = rdata_i;
  endtask
endmodule

/* dv/temp_limit_fault_response_tb.sv */
// Self-checking bench: register access over the link and the fault responses.
// Assumes the host model and the checker bind are compiled alongside.
`timescale 1ns/1ps
module temp_limit_fault_response_tb import temp_limit_pkg::*; ;
  logic        clock_i = 1'b0;
  logic        link_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        link_rst_n_i = 1'b0;
  logic        unit_tick_i = 1'b0;
  logic        ctrl_pin_i = 1'b1;
  logic [15:0] temp_i = 16'h0100;
  logic [1:0]  tick_cnt = 2'h0;
  logic        link_req_i, link_write_i, link_busy_o, link_done_o;
  logic [7:0]  link_code_i;
  logic [15:0] link_wdata_i, link_rdata_o;
  logic        pwr_en_o, ut_fault_o, ut_warn_o, ot_warn_o;
  logic [2:0]  attempts_o;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #12.5 clock_i = ~clock_i;
  initial begin
    #7.3;
    forever #80 link_clk_i = ~link_clk_i;
  end
  // Delay unit of four core cycles keeps retry intervals short
  always @(negedge clock_i) begin
    tick_cnt <= tick_cnt + 2'h1;
    unit_tick_i <= (tick_cnt == 2'h3);
  end

  temp_limit_fault_response i_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .link_clk_i(link_clk_i),
    .link_rst_n_i(link_rst_n_i), .link_req_i(link_req_i), .link_write_i(link_write_i),
    .link_code_i(link_code_i), .link_wdata_i(link_wdata_i), .link_busy_o(link_busy_o),
    .link_done_o(link_done_o), .link_rdata_o(link_rdata_o), .temp_i(temp_i), .unit_tick_i(unit_tick_i),
    .ctrl_pin_i(ctrl_pin_i), .pwr_en_o(pwr_en_o), .ut_fault_o(ut_fault_o), .ut_warn_o(ut_warn_o),
    .ot_warn_o(ot_warn_o), .attempts_o(attempts_o));
  link_host_model i_host (
    .link_clk_i(link_clk_i), .busy_i(link_busy_o), .done_i(link_done_o), .rdata_i(link_rdata_o),
    .req_o(link_req_i), .write_o(link_write_i), .code_o(link_code_i), .wdata_o(link_wdata_i));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic [15:0] q;
    i_host.xfer(1'b1, code, data, q);
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] q;
    i_host.xfer(1'b0, code, 16'h0000, q);
    chk(q, exp);
    cyc(1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic wait_pwr(input logic v);
    int n;
    for (n = 0; n < 400 && pwr_en_o !== v; n++) @(negedge clock_i);
    chk(pwr_en_o, v);
  endtask
  task automatic close_out;
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    close_out();
  end

  initial begin
    int r, n;
    cyc(3);
    rst_n_i = 1'b1;
    repeat (3) @(negedge link_clk_i);
    link_rst_n_i = 1'b1;
    rd(CODE_OT_WARN_LIM, OT_WARN_RESET);
    rd(CODE_UT_WARN_LIM, UT_WARN_RESET);
    rd(CODE_UT_FAULT_LIM, UT_FAULT_RESET);
    rd(CODE_UT_FAULT_RESP, {8'h00, ACTION_RESET});
    wait_pwr(1'b1);
    wr(CODE_OT_WARN_LIM, 16'h0200);
    wr(CODE_UT_WARN_LIM, 16'h0010);
    wr(CODE_UT_FAULT_LIM, 16'h0000);
    rd(CODE_OT_WARN_LIM, 16'h0200);
    rd(CODE_UT_WARN_LIM, 16'h0010);
    rd(CODE_UT_FAULT_LIM, 16'h0000);
    rd(8'h60, 16'h0000);
    temp_i = 16'hfff0;
    cyc(4);
    chk({pwr_en_o, ut_fault_o, ut_warn_o, ot_warn_o}, 16'h000e);
    temp_i = 16'h0300;
    cyc(4);
    rd(CODE_STATUS_TEMP, 16'h0070);
    temp_i = 16'h0100;
    wr(CODE_STATUS_TEMP, 16'h0070);
    rd(CODE_STATUS_TEMP, 16'h0000);
    wr(CODE_UT_FAULT_RESP, 16'h00c0);
    for (r = 0; r < 4; r++) begin
      temp_i = 16'hfff0;
      wait_pwr(1'b0);
      temp_i = 16'h0100;
      cyc(20);
      chk(pwr_en_o, 16'h0000);
      case (r)
        0: wr(CODE_STATUS_TEMP, 16'h0010);
        1: wr(CODE_CLEAR_FAULTS, 16'h0000);
        2: begin
          ctrl_pin_i = 1'b0;
          cyc(4);
          ctrl_pin_i = 1'b1;
        end
        default: begin
          wr(CODE_OPERATION, 16'h0000);
          wr(CODE_OPERATION, 16'h0080);
        end
      endcase
      wait_pwr(1'b1);
    end
    for (r = 0; r < 8; r++) begin
      wr(CODE_UT_FAULT_RESP, {8'h00, RESP_DISABLE, r[2:0], 3'h1});
      temp_i = 16'hfff0;
      wait_pwr(1'b0);
      if (r >= 2 && r < 7) begin
        for (n = 0; n < 200 && attempts_o !== 3'h1; n++) cyc(1);
        for (n = 0; n < 200 && attempts_o === 3'h1; n++) cyc(1);
        chk(n, 16'h0008);
      end
      cyc(60);
      chk(attempts_o, (r == 7) ? 0 : r);
      chk(pwr_en_o, 16'h0000);
      temp_i = 16'h0100;
      if (r == 7) wait_pwr(1'b1);
      wr(CODE_CLEAR_FAULTS, 16'h0000);
      wait_pwr(1'b1);
    end
    wr(CODE_UT_FAULT_RESP, 16'h0042);
    temp_i = 16'hfff0;
    cyc(10);
    chk(pwr_en_o, 16'h0001);
    cyc(20);
    chk(pwr_en_o, 16'h0000);
    close_out();
  end
endmodule
